// >>> core/oed_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface oed_dec_if;
  import oed_pkg::*;
  logic [1:0]   mode;
  logic [2:0]   rm;
  logic         seg_ovr;
  logic [15:0]  disp;
  logic [15:0]  base_reg;
  logic [15:0]  stack_base;
  logic [15:0]  src_idx;
  logic [15:0]  dst_idx;
  logic [3:0]   ea_clks;
  logic [15:0]  ea_addr;
  oed_kind_type kind;
  logic         wide;
  logic [7:0]   byte_const;
  logic [15:0]  acc_word;
  logic [15:0]  port_reg;
  logic [7:0]   count_reg;
  logic [15:0]  port_num;
  logic [7:0]   shift_cnt;
  logic [15:0]  acc_opnd;
  logic [15:0]  table_translate_addr;

  modport ea_src  (output mode, rm, seg_ovr, disp, base_reg, stack_base,
                   src_idx, dst_idx, input ea_clks, ea_addr);
  modport ea_calc (input mode, rm, seg_ovr, disp, base_reg, stack_base,
                   src_idx, dst_idx, output ea_clks, ea_addr);
  modport op_src  (output kind, wide, byte_const, acc_word, port_reg,
                   count_reg, input port_num, shift_cnt, acc_opnd,
                   table_translate_addr);
  modport op_sel  (input kind, wide, byte_const, acc_word, port_reg,
                   count_reg, base_reg, output port_num, shift_cnt,
                   acc_opnd, table_translate_addr);
endinterface
`default_nettype wire

// >>> core/oed_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module oed_decoder
  import oed_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_valid,
  input  wire logic         i_first,
  input  wire logic [7:0]   i_byte,
  input  wire oed_kind_type i_kind,
  input  wire logic [15:0]  i_ip,
  input  wire logic         i_seg_ovr,
  input  wire logic [15:0]  i_accumulator_word,
  input  wire logic [15:0]  i_base_register,
  input  wire logic [15:0]  i_stack_base_register,
  input  wire logic [15:0]  i_source_index_register,
  input  wire logic [15:0]  i_destination_index_register,
  input  wire logic [15:0]  i_port_register,
  input  wire logic [7:0]   i_count_register,
  output logic              o_done,
  output logic [3:0]        o_ea_clocks,
  output logic [15:0]       o_ea_addr,
  output logic [15:0]       o_disp,
  output logic [15:0]       o_imm,
  output logic [15:0]       o_target,
  output logic [15:0]       o_port,
  output logic [7:0]        o_shift_count,
  output logic [7:0]        o_int_type,
  output logic [5:0]        o_esc_code,
  output logic [15:0]       o_pop_count,
  output logic              o_far_dword,
  output logic [15:0]       o_acc_operand,
  output logic [15:0]       o_table_translate_addr,
  output logic [15:0]       o_src_addr,
  output logic [15:0]       o_dst_addr,
  output logic              o_src_ovr,
  output logic              o_range_err
);
  oed_state_type state_q;
  oed_kind_type  kind_q;
  logic [7:0]    op_q;
  logic [7:0]    modrm_q;
  logic [15:0]   ip_q;
  logic [15:0]   len_q;
  logic [15:0]   disp_q;
  logic [15:0]   imm_q;
  logic          disp_wide_q;
  logic          imm_wide_q;
  logic          ovr_q;
  logic          take;
  logic [1:0]    mode;
  logic [15:0]   next_ip;
  logic [15:0]   rel;

  oed_dec_if dif ();

  function automatic logic has_modrm(input oed_kind_type k);
    has_modrm = (k == K_ESC || k == K_MODRM || k == K_MODRM_IMM ||
                 k == K_FAR_IND);
  endfunction

  function automatic logic byte_imm(input oed_kind_type k);
    byte_imm = (k == K_BRANCH || k == K_PORT_IMM || k == K_INT);
  endfunction

  assign take    = i_valid && state_q != S_IDLE && state_q != S_DONE;
  assign mode    = modrm_q[MOD_LSB+1:MOD_LSB];
  assign next_ip = ip_q + len_q;
  assign rel     = o_target - next_ip;

  assign dif.mode       = mode;
  assign dif.rm         = modrm_q[2:0];
  assign dif.seg_ovr    = ovr_q;
  assign dif.disp       = disp_q;
  assign dif.base_reg   = i_base_register;
  assign dif.stack_base = i_stack_base_register;
  assign dif.src_idx    = i_source_index_register;
  assign dif.dst_idx    = i_destination_index_register;
  assign dif.kind       = kind_q;
  assign dif.wide       = op_q[0];
  assign dif.byte_const = imm_q[7:0];
  assign dif.acc_word   = i_accumulator_word;
  assign dif.port_reg   = i_port_register;
  assign dif.count_reg  = i_count_register;

  oed_ea_calc u_ea_calc (
    .ea (dif.ea_calc)
  );

  oed_operand_sel u_operand_sel (
    .op (dif.op_sel)
  );

  // Byte sequencing: opcode, addressing byte, displacement, immediate
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_q <= S_IDLE;
    else
      case (state_q)
        S_IDLE:
          if (i_valid && i_first)
          begin
            if (has_modrm(i_kind))
              state_q <= S_MODRM;
            else if (byte_imm(i_kind) || i_kind == K_RET_POP ||
                     i_kind == K_IMM)
              state_q <= S_IMM_LO;
            else
              state_q <= S_DONE;
          end
        S_MODRM:
          if (i_valid)
          begin
            if (i_byte[7:6] == MOD_DISP8 || i_byte[7:6] == MOD_DISP16 ||
                (i_byte[7:6] == MOD_NO_DISP && i_byte[2:0] == RM_DIRECT))
              state_q <= S_DISP_LO;
            else if (kind_q == K_MODRM_IMM)
              state_q <= S_IMM_LO;
            else
              state_q <= S_DONE;
          end
        S_DISP_LO:
          if (i_valid)
          begin
            if (disp_wide_q)
              state_q <= S_DISP_HI;
            else if (kind_q == K_MODRM_IMM)
              state_q <= S_IMM_LO;
            else
              state_q <= S_DONE;
          end
        S_DISP_HI:
          if (i_valid)
            state_q <= (kind_q == K_MODRM_IMM) ? S_IMM_LO : S_DONE;
        S_IMM_LO:
          if (i_valid)
            state_q <= imm_wide_q ? S_IMM_HI : S_DONE;
        S_IMM_HI:
          if (i_valid)
            state_q <= S_DONE;
        default:
          state_q <= S_IDLE;
      endcase
  end

  // Opcode context, held for the whole instruction
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      kind_q     <= K_NONE;
      op_q       <= 8'h00;
      ip_q       <= 16'h0000;
      ovr_q      <= 1'b0;
      imm_wide_q <= 1'b0;
    end
    else if (state_q == S_IDLE && i_valid && i_first)
    begin
      kind_q     <= i_kind;
      op_q       <= i_byte;
      ip_q       <= i_ip;
      ovr_q      <= i_seg_ovr;
      // Return count always 16-bit; branch, port and interrupt constants 8-bit; others follow the width bit
      imm_wide_q <= (i_kind == K_RET_POP) ||
                    (!byte_imm(i_kind) && i_byte[0]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      len_q <= 16'h0000;
    else if (state_q == S_IDLE && i_valid && i_first)
      len_q <= ONE16;
    else if (take)
      len_q <= len_q + ONE16;
  end

  // Addressing byte and displacement
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      modrm_q     <= 8'h00;
      disp_q      <= 16'h0000;
      disp_wide_q <= 1'b0;
    end
    else if (state_q == S_IDLE && i_valid && i_first)
    begin
      modrm_q <= {MOD_REG, 6'h00};
      disp_q  <= 16'h0000;
    end
    else if (state_q == S_MODRM && i_valid)
    begin
      modrm_q     <= i_byte;
      disp_wide_q <= i_byte[7:6] == MOD_DISP16 ||
                     (i_byte[7:6] == MOD_NO_DISP &&
                      i_byte[2:0] == RM_DIRECT);
    end
    else if (state_q == S_DISP_LO && i_valid)
      disp_q <= {{8{i_byte[7]}}, i_byte};
    else if (state_q == S_DISP_HI && i_valid)
      disp_q <= {i_byte, disp_q[7:0]};
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      imm_q <= 16'h0000;
    else if (state_q == S_IDLE && i_valid && i_first)
      imm_q <= 16'h0000;
    else if (state_q == S_IMM_LO && i_valid)
      imm_q <= {8'h00, i_byte};
    else if (state_q == S_IMM_HI && i_valid)
      imm_q <= {i_byte, imm_q[7:0]};
  end

  // Results: registers are only read here, never written back
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ea_clocks   <= 4'h0;
      o_ea_addr     <= 16'h0000;
      o_disp        <= 16'h0000;
      o_imm         <= 16'h0000;
      o_target      <= 16'h0000;
      o_port        <= 16'h0000;
      o_shift_count <= 8'h00;
      o_int_type    <= 8'h00;
      o_esc_code    <= 6'h00;
      o_pop_count   <= 16'h0000;
      o_far_dword   <= 1'b0;
      o_acc_operand <= 16'h0000;
      o_table_translate_addr   <= 16'h0000;
      o_src_addr    <= 16'h0000;
      o_dst_addr    <= 16'h0000;
      o_src_ovr     <= 1'b0;
    end
    else if (state_q == S_DONE)
    begin
      o_ea_clocks   <= dif.ea_clks;
      o_ea_addr     <= dif.ea_addr;
      o_disp        <= disp_q;
      o_imm         <= imm_q;
      o_target      <= next_ip + {{8{imm_q[7]}}, imm_q[7:0]};
      o_port        <= dif.port_num;
      o_shift_count <= dif.shift_cnt;
      o_int_type    <= imm_q[7:0];
      o_esc_code    <= {op_q[2:0], modrm_q[5:3]};
      o_pop_count   <= imm_q;
      o_far_dword   <= kind_q == K_FAR_IND && mode != MOD_REG;
      o_acc_operand <= dif.acc_opnd;
      o_table_translate_addr   <= dif.table_translate_addr;
      o_src_addr    <= i_source_index_register;
      o_dst_addr    <= i_destination_index_register;
      o_src_ovr     <= kind_q == K_STRING && ovr_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_done <= 1'b0;
    else
      o_done <= state_q == S_DONE;
  end

  // Field widths make an out-of-reach target unencodable
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_range_err <= 1'b0;
    else
      o_range_err <= o_done && kind_q == K_BRANCH &&
                     $signed(rel) > $signed(BR_MAX);
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence seq_disp8_taken;
    state_q == S_DISP_LO && i_valid && !disp_wide_q;
  endsequence

  sequence seq_ret_start;
    state_q == S_IDLE && i_valid && i_first && i_kind == K_RET_POP;
  endsequence

  a_disp_sign_ext: assert property (
    seq_disp8_taken |=> disp_q == {{8{$past(i_byte[7])}}, $past(i_byte)})
    else $error("Short displacement not sign-extended");

  a_direct_ea_addr: assert property (
    (mode == MOD_NO_DISP && dif.rm == RM_DIRECT) |->
      (dif.ea_addr == disp_q &&
       dif.ea_clks == (ovr_q ? EA_DISP_ONLY + EA_OVERRIDE : EA_DISP_ONLY)))
    else $error("Direct address form wrong");

  a_pair_disp_cost: assert property (
    (mode == MOD_DISP16 && dif.rm == 3'h1 && !ovr_q) |->
      dif.ea_clks == EA_PAIR_SLOW_DISP)
    else $error("Indexed pair cost wrong");

  a_override_cost: assert property (
    (mode == MOD_NO_DISP && dif.rm == 3'h4 && ovr_q) |->
      dif.ea_clks == EA_BASE_ONLY + EA_OVERRIDE)
    else $error("Override did not add two clocks");

  a_disp_before_imm: assert property (
    (state_q == S_DISP_HI && i_valid) |=>
      (state_q == S_IMM_LO || state_q == S_DONE))
    else $error("Displacement not before immediate");

  a_ret_pop_count: assert property (
    seq_ret_start ##1 i_valid[*2] |=> ##1 o_done && o_pop_count ==
      {$past(i_byte, 2), $past(i_byte, 3)})
    else $error("Return pop count wrong");

  a_esc_code_out: assert property (
    state_q == S_DONE && kind_q == K_ESC |=>
      o_esc_code == {$past(op_q[2:0]), $past(modrm_q[5:3])})
    else $error("Escape code wrong");

  a_shift_one_cnt: assert property (
    o_done && kind_q == K_SHIFT_ONE |-> o_shift_count == SHIFT_ONE)
    else $error("Fixed shift count not one");

  a_branch_reach: assert property (
    o_done && kind_q == K_BRANCH |->
      ($signed(rel) >= $signed(BR_MIN) && !o_range_err))
    else $error("Branch outside short reach");
endmodule // oed_decoder
`default_nettype wire

// >>> core/oed_ea_calc.sv
`timescale 1ns/1ps
`default_nettype none
module oed_ea_calc
  import oed_pkg::*;
(
  oed_dec_if.ea_calc ea
);
  logic [3:0]  base_clks;
  logic [15:0] reg_sum;

  always_comb
  begin
    base_clks = EA_BASE_ONLY;
    reg_sum   = 16'h0000;
    case (ea.rm)
      3'h0: reg_sum = ea.base_reg + ea.src_idx;
      3'h1: reg_sum = ea.base_reg + ea.dst_idx;
      3'h2: reg_sum = ea.stack_base + ea.src_idx;
      3'h3: reg_sum = ea.stack_base + ea.dst_idx;
      3'h4: reg_sum = ea.src_idx;
      3'h5: reg_sum = ea.dst_idx;
      3'h6: reg_sum = ea.stack_base;
      default: reg_sum = ea.base_reg;
    endcase
    // Fast pairs are the diagonal ones
    if (ea.rm == 3'h0 || ea.rm == 3'h3)
      base_clks = (ea.mode == MOD_NO_DISP) ? EA_PAIR_FAST
                                            : EA_PAIR_FAST_DISP;
    else if (ea.rm == 3'h1 || ea.rm == 3'h2)
      base_clks = (ea.mode == MOD_NO_DISP) ? EA_PAIR_SLOW
                                            : EA_PAIR_SLOW_DISP;
    else
      base_clks = (ea.mode == MOD_NO_DISP) ? EA_BASE_ONLY
                                            : EA_DISP_BASE;
    if (ea.mode == MOD_NO_DISP && ea.rm == RM_DIRECT)
    begin
      base_clks = EA_DISP_ONLY;
      reg_sum   = 16'h0000;
    end
    if (ea.mode == MOD_REG)
      base_clks = 4'h0;
  end

  assign ea.ea_addr = reg_sum + ea.disp;
  assign ea.ea_clks = (ea.seg_ovr && ea.mode != MOD_REG)
                      ? base_clks + EA_OVERRIDE : base_clks;
endmodule // oed_ea_calc
`default_nettype wire

// >>> core/oed_operand_sel.sv
`timescale 1ns/1ps
`default_nettype none
module oed_operand_sel
  import oed_pkg::*;
(
  oed_dec_if.op_sel op
);
  always_comb
  begin
    op.port_num  = {8'h00, op.byte_const};
    if (op.kind == K_PORT_REG)
      op.port_num = op.port_reg;
    op.shift_cnt = (op.kind == K_SHIFT_CNT) ? op.count_reg
                                            : SHIFT_ONE;
    op.acc_opnd  = op.wide ? op.acc_word
                           : {8'h00, op.acc_word[7:0]};
    // Table index is one byte, so reach is exactly 256 bytes
    op.table_translate_addr = op.base_reg + {8'h00, op.acc_word[7:0]};
  end
endmodule // oed_operand_sel
`default_nettype wire

// >>> core/oed_pkg.sv
// Summary of operation
// - Short branch reach is -128 to +127
// - Port from byte constant or port register
// - Shift count is one or count register
// - Interrupt type is an 8-bit constant
// - Escape carries 6-bit code for coprocessor
// - Return pops a 16-bit byte count
// - Port data uses word or low byte
// - Translate indexes 256-byte table at base
// - Strings read through source index, override allowed
// - Strings write through destination index register
// - Sources are read, only destination changes
// - Immediates span 16-bit or 8-bit range
// - Far indirect transfer through a memory operand fetches a doubleword
// - EA costs 5, 6, 7, 8, 9, 11 or 12 clocks
// - Segment override adds two EA clocks
// - Mode 01 sign-extends one displacement byte
// - Mode 00 code 110 is direct address
// - Displacement precedes immediate data bytes
package oed_pkg;
  localparam logic [3:0] EA_DISP_ONLY      = 4'h6;
  localparam logic [3:0] EA_BASE_ONLY      = 4'h5;
  localparam logic [3:0] EA_DISP_BASE      = 4'h9;
  localparam logic [3:0] EA_PAIR_FAST      = 4'h7;
  localparam logic [3:0] EA_PAIR_SLOW      = 4'h8;
  localparam logic [3:0] EA_PAIR_FAST_DISP = 4'hb;
  localparam logic [3:0] EA_PAIR_SLOW_DISP = 4'hc;
  localparam logic [3:0] EA_OVERRIDE       = 4'h2;
  localparam logic [1:0] MOD_NO_DISP = 2'h0;
  localparam logic [1:0] MOD_DISP8   = 2'h1;
  localparam logic [1:0] MOD_DISP16  = 2'h2;
  localparam logic [1:0] MOD_REG     = 2'h3;
  localparam logic [2:0] RM_DIRECT   = 3'h6;
  localparam int         MOD_LSB     = 6;
  localparam int         REG_LSB     = 3;
  localparam logic [7:0] SHIFT_ONE   = 8'h01;
  localparam logic [15:0] ONE16      = 16'h0001;
  localparam logic [15:0] BR_MIN     = 16'hff80;
  localparam logic [15:0] BR_MAX     = 16'h007f;

  typedef enum logic [3:0] {
    K_NONE      = 4'h0,
    K_BRANCH    = 4'h1,
    K_PORT_IMM  = 4'h2,
    K_PORT_REG  = 4'h3,
    K_SHIFT_ONE = 4'h4,
    K_SHIFT_CNT = 4'h5,
    K_INT       = 4'h6,
    K_ESC       = 4'h7,
    K_RET_POP   = 4'h8,
    K_MODRM     = 4'h9,
    K_MODRM_IMM = 4'ha,
    K_FAR_IND   = 4'hb,
    K_TABLE_TRANSLATE      = 4'hc,
    K_STRING    = 4'hd,
    K_IMM       = 4'he
  } oed_kind_type;

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_MODRM   = 3'h1,
    S_DISP_LO = 3'h2,
    S_DISP_HI = 3'h3,
    S_IMM_LO  = 3'h4,
    S_IMM_HI  = 3'h5,
    S_DONE    = 3'h6
  } oed_state_type;
endpackage

// >>> tb/oed_stream_model.sv
`timescale 1ns/1ps
`default_nettype none
module oed_stream_model
  import oed_pkg::*;
(
  input  wire logic    i_clk,
  output logic         o_valid,
  output logic         o_first,
  output logic [7:0]   o_byte,
  output oed_kind_type o_kind,
  output logic [15:0]  o_ip,
  output logic         o_seg_ovr
);
  // Largest idle gap between bytes; the bench may shrink it
  int gap_max = 2;

  initial
  begin
    o_valid   = 1'b0;
    o_first   = 1'b0;
    o_byte    = 8'h00;
    o_kind    = K_NONE;
    o_ip      = 16'h0000;
    o_seg_ovr = 1'b0;
  end

  // Bytes go low first with random gaps; idle lines show inverted data
  task automatic send(input oed_kind_type k, input logic [15:0] ip,
                      input logic ov, input logic [7:0] b[$]);
    int g;
    for (int i = 0; i < b.size(); i++)
    begin
      o_valid = 1'b1;
      o_first = (i == 0);
      o_byte  = b[i];
      if (i == 0)
      begin
        o_kind    = k;
        o_ip      = ip;
        o_seg_ovr = ov;
      end
      @(posedge i_clk);
      #1;
      if (i == 0)
      begin
        o_kind = K_NONE;
        o_ip   = ~ip;
      end
      // No gap after the last byte, else the done pulse is missed
      g = (i == b.size() - 1) ? 0 : $urandom_range(0, gap_max);
      if (g > 0 || i == b.size() - 1)
      begin
        o_valid = 1'b0;
        o_first = 1'b0;
        o_byte  = ~b[i];
      end
      repeat (g)
      begin
        @(posedge i_clk);
        #1;
      end
    end
  endtask
endmodule // oed_stream_model
`default_nettype wire

// >>> tb/operand_decode_ea_timing_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module operand_decode_ea_timing_tb_top
  import oed_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic v, f, ov_w, done, far, rerr, sovr;
  logic [7:0] b, sc, it, cl;
  logic [5:0] coprocessor_escape;
  logic [3:0] eac;
  logic [15:0] ip_w, acc, bx, bp, si, di, dx, ea, dsp, imm, tgt, prt, pop;
  logic [15:0] aop, xa, sa, da, ip;
  oed_kind_type kd;
  logic [7:0] q[$];
  int err_count = 0;
  int check_count = 0;

  always #20 i_clk = ~i_clk;

  oed_stream_model oed_stream_model_inst (.i_clk(i_clk), .o_valid(v),
    .o_first(f), .o_byte(b), .o_kind(kd), .o_ip(ip_w), .o_seg_ovr(ov_w));

  oed_decoder oed_decoder_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_valid(v), .i_first(f), .i_byte(b), .i_kind(kd), .i_ip(ip_w),
    .i_seg_ovr(ov_w), .i_accumulator_word(acc), .i_base_register(bx),
    .i_stack_base_register(bp), .i_source_index_register(si),
    .i_destination_index_register(di), .i_port_register(dx),
    .i_count_register(cl), .o_done(done), .o_ea_clocks(eac),
    .o_ea_addr(ea), .o_disp(dsp), .o_imm(imm), .o_target(tgt),
    .o_port(prt), .o_shift_count(sc), .o_int_type(it), .o_esc_code(coprocessor_escape),
    .o_pop_count(pop), .o_far_dword(far), .o_acc_operand(aop),
    .o_table_translate_addr(xa), .o_src_addr(sa), .o_dst_addr(da), .o_src_ovr(sovr),
    .o_range_err(rerr));

  function automatic logic [15:0] sx(input logic [7:0] x);
    return {{8{x[7]}}, x};
  endfunction

  function automatic logic [3:0] cost(input logic [1:0] md,
                                      input logic [2:0] rm, input logic o);
    logic [3:0] c;
    if (md == 2'h0 && rm == 3'h6)
      c = 4'h6;
    else if (rm[2])
      c = (md != 2'h0) ? 4'h9 : 4'h5;
    else if (rm[1] ^ rm[0])
      c = (md != 2'h0) ? 4'hc : 4'h8;
    else
      c = (md != 2'h0) ? 4'hb : 4'h7;
    return c + (o ? 4'h2 : 4'h0);
  endfunction

  function automatic logic [15:0] eaddr(input logic [1:0] md,
                                        input logic [2:0] rm,
                                        input logic [15:0] d);
    logic [15:0] r [8];
    r = '{bx + si, bx + di, bp + si, bp + di, si, di, bp, bx};
    if (md == 2'h0 && rm == 3'h6)
      return d;
    return r[rm] + d;
  endfunction

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Fresh registers each transfer, held until the answer
  task automatic run(input oed_kind_type k, input logic o);
    int n;
    {acc, bx, bp, si} = {$urandom, $urandom};
    {di, dx, ip} = 48'({$urandom, $urandom});
    cl = 8'($urandom);
    oed_stream_model_inst.send(k, ip, o, q);
    n = 0;
    while (done !== 1'b1 && n < 12)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("done", {15'h0, done}, 16'h0001);
  endtask

  initial
  begin
    logic [7:0] x, y, op;
    logic [1:0] md;
    logic o;
    logic [3:0] ec;
    logic [15:0] d;
    logic [7:0] bv [4];
    acc = 16'h0;
    {bx, bp, si, di, dx, ip} = '0;
    cl = 8'h0;
    void'($urandom(80439));
    repeat (2) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    bv = '{8'h80, 8'h7f, 8'h00, 8'h00};
    bv[3] = 8'($urandom);
    foreach (bv[i])
    begin
      q = '{8'h74, bv[i]};
      run(K_BRANCH, 1'b0);
      check("target", tgt, ip + 16'h0002 + sx(bv[i]));
      @(posedge i_clk);
      #1;
      check("range", {15'h0, rerr}, 16'h0);
    end
    x = 8'($urandom);
    q = '{8'he5, x};
    run(K_PORT_IMM, 1'b0);
    check("port_imm", prt, {8'h00, x});
    check("acc_word", aop, acc);
    q = '{8'hec};
    run(K_PORT_REG, 1'b0);
    check("port_reg", prt, dx);
    check("acc_low", aop, {8'h00, acc[7:0]});
    q = '{8'hd1};
    run(K_SHIFT_ONE, 1'b0);
    check("shift_one", {8'h00, sc}, 16'h0001);
    q = '{8'hd3};
    run(K_SHIFT_CNT, 1'b0);
    check("shift_cnt", {8'h00, sc}, {8'h00, cl});
    q = '{8'hcd, 8'hff};
    run(K_INT, 1'b0);
    check("int_type", {8'h00, it}, 16'h00ff);
    for (int i = 0; i < 4; i++)
    begin
      x = 8'($urandom);
      op = {5'h1b, x[2:0]};
      y = {2'h3, x[5:3], 3'h0};
      q = '{op, y};
      run(K_ESC, 1'b0);
      check("esc", {10'h0, coprocessor_escape}, {10'h0, x[2:0], x[5:3]});
    end
    // Back-to-back bytes, so the pop-count property sees its walk
    oed_stream_model_inst.gap_max = 0;
    {x, y} = {8'($urandom), 8'hff};
    q = '{8'hc2, x, y};
    run(K_RET_POP, 1'b0);
    check("pop", pop, {y, x});
    oed_stream_model_inst.gap_max = 2;
    q = '{8'hd7};
    run(K_TABLE_TRANSLATE, 1'b0);
    check("table_translate", xa, bx + {8'h00, acc[7:0]});
    q = '{8'ha5};
    run(K_STRING, 1'b1);
    check("src", sa, si);
    check("src_ovr", {15'h0, sovr}, 16'h0001);
    check("dst", da, di);
    q = '{8'ha4};
    run(K_STRING, 1'b0);
    check("src_plain", {15'h0, sovr}, 16'h0000);
    q = '{8'hff, 8'h1f};
    run(K_FAR_IND, 1'b0);
    check("far", {15'h0, far}, 16'h0001);
    q = '{8'hff, 8'hdb};
    run(K_FAR_IND, 1'b0);
    check("far_reg", {15'h0, far}, 16'h0000);
    for (int m = 0; m < 3; m++)
    begin
      for (int r = 0; r < 8; r++)
      begin
        md = m[1:0];
        {x, y, o} = 17'($urandom);
        q = '{8'h8b, {md, 3'h2, r[2:0]}};
        if (md == 2'h1)
          q.push_back(x);
        if (md == 2'h2 || (md == 2'h0 && r == 6))
          q = {q, x, y};
        run(K_MODRM, o);
        ec = cost(md, r[2:0], o);
        check("ea_clk", {12'h0, eac}, {12'h0, ec});
        if (md == 2'h1)
          check("disp8", dsp, sx(x));
        d = (md == 2'h1) ? sx(x) : {y, x};
        if (md == 2'h0 && r != 6)
          d = 16'h0000;
        if (md == 2'h0)
          check("ea", ea, eaddr(md, r[2:0], d));
        else
          check("ea", ea, eaddr(md, r[2:0], d));
      end
    end
    q = '{8'h8b, 8'hc0};
    run(K_MODRM, 1'b1);
    check("ea_reg", {12'h0, eac}, 16'h0);
    q = '{8'h8b, 8'h04};
    run(K_MODRM, 1'b1);
    ec = cost(2'h0, 3'h4, 1'b1);
    check("ea_ovr", {12'h0, eac}, {12'h0, ec});
    {x, y} = 16'($urandom);
    q = '{8'h8b, 8'h91, x, y};
    run(K_MODRM, 1'b0);
    ec = cost(2'h2, 3'h1, 1'b0);
    check("ea_pair", {12'h0, eac}, {12'h0, ec});
    for (int i = 0; i < 4; i++)
    begin
      {x, y} = 16'($urandom);
      op = {7'h40, i[0]};
      q = '{op, 8'h87, 8'h34, 8'h12, x};
      if (i[0])
        q.push_back(y);
      run(K_MODRM_IMM, 1'b0);
      check("disp16", dsp, 16'h1234);
      check("imm", imm, i[0] ? {y, x} : {8'h00, x});
      q = '{op | 8'hb0, y, x};
      if (!i[0])
        void'(q.pop_back());
      run(K_IMM, 1'b0);
      check("imm", imm, i[0] ? {x, y} : {8'h00, y});
    end
    stop_test();
  end

  initial
  begin
    #(40 * 20000);
    err_count++;
    stop_test();
  end
endmodule // operand_decode_ea_timing_tb_top
`default_nettype wire
